/* hdl/vdst_pkg.sv */
// Operation
// - In BT.656 and Y/C modes during field 1 a luma fill request is raised only while the luma FIFO has at least the field 1 threshold of double words free.
// - In BT.656 and Y/C modes during field 1 a chroma fill request is raised only while that chroma FIFO has at least half the field 1 threshold free.
// - In raw mode during field 1 a fill request is raised only while the single FIFO has at least the field 1 threshold free.
// - Reserved bits of the threshold and sync registers read as zero and ignore writes.
// - Horizontal sync goes active when the pixel counter equals the programmed assert pixel.
// - Horizontal sync goes inactive when the pixel counter equals the programmed release pixel, unless that is also the assert pixel.
// - In field 1 vertical sync goes active when line and pixel counters equal the assert line and pixel.
// - In field 1 vertical sync goes inactive when line and pixel counters equal the release line and pixel, unless those equal the assert line and pixel.
// - The chroma threshold is half the programmed threshold, rounded up when it is odd.
// - During field 2 the field 2 threshold replaces the field 1 threshold.
// - In raw mode the pixel counter advances once every N output clocks, N being the step divider with 0 meaning 16.
package vdst_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 12;
    localparam int THR_W = 10;
    localparam int STEP_W = 4;

    // register byte offsets
    localparam logic [7:0] OFF_THRESHOLD = 8'h00;
    localparam logic [7:0] OFF_HSYNC = 8'h04;
    localparam logic [7:0] OFF_VSYNC_START = 8'h08;
    localparam logic [7:0] OFF_VSYNC_END = 8'h0c;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_GEOMETRY = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // field positions
    localparam int THR1_LSB = 0;
    localparam int STEP_LSB = 12;
    localparam int THR2_LSB = 16;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 16;
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_LSB = 1;
    localparam int ST_HSYNC_BIT = 28;
    localparam int ST_VSYNC_BIT = 29;
    localparam int ST_FIELD2_BIT = 30;

    // reset values
    localparam logic [STEP_W-1:0] STEP_RESET = 4'h1;
    localparam logic [THR_W-1:0] THR_RESET = 10'h000;
    localparam logic [POS_W-1:0] POS_RESET = 12'h000;

    typedef enum logic [1:0] {
        VDST_MODE_BT656,
        VDST_MODE_YC,
        VDST_MODE_RAW,
        VDST_MODE_OFF
    } vdst_mode_e;

    // host register port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } vdst_bus_s;

    // free space of the display FIFOs, double words
    typedef struct packed {
        logic [THR_W:0] luma;
        logic [THR_W:0] cb;
        logic [THR_W:0] cr;
    } vdst_space_s;

    typedef struct packed {
        logic luma;
        logic cb;
        logic cr;
    } vdst_fill_s;

endpackage

/* hdl/vdst_sync_edge.sv */
`timescale 1ns/10ps
// set/clear level generator for one sync output
module vdst_sync_edge (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    input wire logic set_in,
    input wire logic clear_in,
    // level
    output logic level_out
);

    typedef struct packed {
        logic level;
    } vdst_edge_s;

    vdst_edge_s state_ff;
    vdst_edge_s nxt_state;

    // set wins when both positions coincide, so equal programming gives a
    // steady active level instead of a pulse that never shows
    always_comb begin
        nxt_state = state_ff;
        if (!run_in) begin
            nxt_state.level = 1'b0;
        end else if (set_in) begin
            nxt_state.level = 1'b1;
        end else if (clear_in) begin
            nxt_state.level = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level_out = state_ff.level;

endmodule

/* hdl/vdst_timing.sv */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/10ps
module vdst_timing #(
    parameter int POS_W = vdst_pkg::POS_W,
    parameter int THR_W = vdst_pkg::THR_W
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // host register port
    input wire vdst_pkg::vdst_bus_s bus_in,
    output logic [vdst_pkg::DATA_W-1:0] rdata_out,
    // display FIFO side, same clock
    input wire vdst_pkg::vdst_space_s space_in,
    input wire logic field2_in,
    output vdst_pkg::vdst_fill_s fill_req_out,
    // display sync outputs
    output logic hsync_out,
    output logic vsync_out,
    // counter view
    output logic [POS_W-1:0] frame_pixel_counter_out,
    output logic [POS_W-1:0] frame_line_counter_out
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (POS_W != vdst_pkg::POS_W || THR_W != vdst_pkg::THR_W) begin : g_bad_width
        $error("register field widths are fixed by the register layout");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [THR_W-1:0] field1_fifo_threshold;
        logic [THR_W-1:0] field2_fifo_threshold;
        logic [3:0] pixel_step_divider;
        logic [POS_W-1:0] hsync_assert_pixel;
        logic [POS_W-1:0] hsync_release_pixel;
        logic [POS_W-1:0] f1_vsync_assert_line;
        logic [POS_W-1:0] f1_vsync_assert_pixel;
        logic [POS_W-1:0] f1_vsync_release_line;
        logic [POS_W-1:0] f1_vsync_release_pixel;
        logic run;
        vdst_pkg::vdst_mode_e mode;
        logic [POS_W-1:0] line_last_pixel;
        logic [POS_W-1:0] frame_last_line;
        logic [POS_W-1:0] frame_pixel_counter;
        logic [POS_W-1:0] frame_line_counter;
        logic [4:0] step_count;
        vdst_pkg::vdst_fill_s fill;
        logic [vdst_pkg::DATA_W-1:0] rdata;
    } vdst_state_s;

    vdst_state_s state_ff;
    vdst_state_s nxt_state;

    logic hsync_level;
    logic vsync_level;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // half a threshold, rounded up to a whole double word
    function automatic logic [THR_W-1:0] half_up(input logic [THR_W-1:0] thr);
        logic [THR_W-1:0] half;
        half = {1'b0, thr[THR_W-1:1]};
        return half + {{(THR_W-1){1'b0}}, thr[0]};
    endfunction

    // step divider value 0 stands for 16
    function automatic logic [4:0] step_len(input logic [3:0] setting);
        return (setting == 4'h0) ? 5'h10 : {1'b0, setting};
    endfunction

    function automatic logic [vdst_pkg::DATA_W-1:0] pack_pair(
        input logic [POS_W-1:0] hi,
        input logic [POS_W-1:0] lo
    );
        logic [vdst_pkg::DATA_W-1:0] word;
        word = '0;
        word[vdst_pkg::HI_LSB +: POS_W] = hi;
        word[vdst_pkg::LO_LSB +: POS_W] = lo;
        return word;
    endfunction

    // ----------------------------------------------------------------
    // derived terms
    // ----------------------------------------------------------------
    logic [THR_W-1:0] luma_thr;
    logic [THR_W-1:0] chroma_thr;
    logic yc_like;
    logic raw_mode;
    logic pixel_step;
    logic line_end;
    logic hs_set;
    logic hs_clear;
    logic vs_set;
    logic vs_clear;

    always_comb begin
        // field 2 evaluates free space against its own threshold
        luma_thr = field2_in ? state_ff.field2_fifo_threshold
                             : state_ff.field1_fifo_threshold;
        chroma_thr = half_up(luma_thr);
        yc_like = (state_ff.mode == vdst_pkg::VDST_MODE_BT656)
                || (state_ff.mode == vdst_pkg::VDST_MODE_YC);
        raw_mode = (state_ff.mode == vdst_pkg::VDST_MODE_RAW);
        // raw mode steps once every divider count of output clocks
        pixel_step = state_ff.run && (!raw_mode
            || (state_ff.step_count == step_len(state_ff.pixel_step_divider) - 5'h01));
        line_end = (state_ff.frame_pixel_counter == state_ff.line_last_pixel);
        hs_set = (state_ff.frame_pixel_counter == state_ff.hsync_assert_pixel);
        hs_clear = (state_ff.frame_pixel_counter == state_ff.hsync_release_pixel);
        vs_set = !field2_in
            && (state_ff.frame_line_counter == state_ff.f1_vsync_assert_line)
            && (state_ff.frame_pixel_counter == state_ff.f1_vsync_assert_pixel);
        vs_clear = !field2_in
            && (state_ff.frame_line_counter == state_ff.f1_vsync_release_line)
            && (state_ff.frame_pixel_counter == state_ff.f1_vsync_release_pixel);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;

        // register writes keep only defined fields; reserved bits drop
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                vdst_pkg::OFF_THRESHOLD: begin
                    nxt_state.field1_fifo_threshold =
                        bus_in.wdata[vdst_pkg::THR1_LSB +: THR_W];
                    nxt_state.pixel_step_divider =
                        bus_in.wdata[vdst_pkg::STEP_LSB +: vdst_pkg::STEP_W];
                    nxt_state.field2_fifo_threshold =
                        bus_in.wdata[vdst_pkg::THR2_LSB +: THR_W];
                end
                vdst_pkg::OFF_HSYNC: begin
                    nxt_state.hsync_assert_pixel = bus_in.wdata[vdst_pkg::LO_LSB +: POS_W];
                    nxt_state.hsync_release_pixel = bus_in.wdata[vdst_pkg::HI_LSB +: POS_W];
                end
                vdst_pkg::OFF_VSYNC_START: begin
                    nxt_state.f1_vsync_assert_pixel = bus_in.wdata[vdst_pkg::LO_LSB +: POS_W];
                    nxt_state.f1_vsync_assert_line = bus_in.wdata[vdst_pkg::HI_LSB +: POS_W];
                end
                vdst_pkg::OFF_VSYNC_END: begin
                    nxt_state.f1_vsync_release_pixel = bus_in.wdata[vdst_pkg::LO_LSB +: POS_W];
                    nxt_state.f1_vsync_release_line = bus_in.wdata[vdst_pkg::HI_LSB +: POS_W];
                end
                vdst_pkg::OFF_CONTROL: begin
                    nxt_state.run = bus_in.wdata[vdst_pkg::CTL_EN_BIT];
                    nxt_state.mode = vdst_pkg::vdst_mode_e'(bus_in.wdata[vdst_pkg::CTL_MODE_LSB +: 2]);
                end
                vdst_pkg::OFF_GEOMETRY: begin
                    nxt_state.line_last_pixel = bus_in.wdata[vdst_pkg::LO_LSB +: POS_W];
                    nxt_state.frame_last_line = bus_in.wdata[vdst_pkg::HI_LSB +: POS_W];
                end
                default: begin
                end
            endcase
        end

        // read data stand for exactly the cycle after the strobe
        nxt_state.rdata = '0;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                vdst_pkg::OFF_THRESHOLD: begin
                    nxt_state.rdata[vdst_pkg::THR1_LSB +: THR_W] =
                        state_ff.field1_fifo_threshold;
                    nxt_state.rdata[vdst_pkg::STEP_LSB +: vdst_pkg::STEP_W] =
                        state_ff.pixel_step_divider;
                    nxt_state.rdata[vdst_pkg::THR2_LSB +: THR_W] =
                        state_ff.field2_fifo_threshold;
                end
                vdst_pkg::OFF_HSYNC: begin
                    nxt_state.rdata = pack_pair(state_ff.hsync_release_pixel,
                        state_ff.hsync_assert_pixel);
                end
                vdst_pkg::OFF_VSYNC_START: begin
                    nxt_state.rdata = pack_pair(state_ff.f1_vsync_assert_line,
                        state_ff.f1_vsync_assert_pixel);
                end
                vdst_pkg::OFF_VSYNC_END: begin
                    nxt_state.rdata = pack_pair(state_ff.f1_vsync_release_line,
                        state_ff.f1_vsync_release_pixel);
                end
                vdst_pkg::OFF_CONTROL: begin
                    nxt_state.rdata[vdst_pkg::CTL_EN_BIT] = state_ff.run;
                    nxt_state.rdata[vdst_pkg::CTL_MODE_LSB +: 2] = state_ff.mode;
                end
                vdst_pkg::OFF_GEOMETRY: begin
                    nxt_state.rdata = pack_pair(state_ff.frame_last_line,
                        state_ff.line_last_pixel);
                end
                vdst_pkg::OFF_STATUS: begin
                    nxt_state.rdata = pack_pair(state_ff.frame_line_counter,
                        state_ff.frame_pixel_counter);
                    nxt_state.rdata[vdst_pkg::ST_HSYNC_BIT] = hsync_level;
                    nxt_state.rdata[vdst_pkg::ST_VSYNC_BIT] = vsync_level;
                    nxt_state.rdata[vdst_pkg::ST_FIELD2_BIT] = field2_in;
                end
                default: begin
                end
            endcase
        end

        // frame counters; held at zero while the channel is stopped
        if (!state_ff.run) begin
            nxt_state.frame_pixel_counter = '0;
            nxt_state.frame_line_counter = '0;
            nxt_state.step_count = '0;
        end else begin
            if (raw_mode && !pixel_step) begin
                nxt_state.step_count = state_ff.step_count + 5'h01;
            end else begin
                nxt_state.step_count = '0;
            end
            if (pixel_step) begin
                if (line_end) begin
                    nxt_state.frame_pixel_counter = '0;
                    if (state_ff.frame_line_counter == state_ff.frame_last_line) begin
                        nxt_state.frame_line_counter = '0;
                    end else begin
                        nxt_state.frame_line_counter =
                            state_ff.frame_line_counter + 12'h001;
                    end
                end else begin
                    nxt_state.frame_pixel_counter = state_ff.frame_pixel_counter + 12'h001;
                end
            end
        end

        // fill requests gated by free space against the active threshold
        nxt_state.fill.luma = state_ff.run && (yc_like || raw_mode)
            && (space_in.luma >= {1'b0, luma_thr});
        nxt_state.fill.cb = state_ff.run && yc_like
            && (space_in.cb >= {1'b0, chroma_thr});
        nxt_state.fill.cr = state_ff.run && yc_like
            && (space_in.cr >= {1'b0, chroma_thr});
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= '0;
            state_ff.pixel_step_divider <= vdst_pkg::STEP_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // sync outputs
    // ----------------------------------------------------------------
    vdst_sync_edge u_hsync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .run_in(state_ff.run),
        .set_in(hs_set),
        .clear_in(hs_clear),
        .level_out(hsync_level)
    );

    // field 2 compares are not built here; the level just holds in field 2
    vdst_sync_edge u_vsync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .run_in(state_ff.run),
        .set_in(vs_set),
        .clear_in(vs_clear),
        .level_out(vsync_level)
    );

    assign hsync_out = hsync_level;
    assign vsync_out = vsync_level;
    assign rdata_out = state_ff.rdata;
    assign fill_req_out = state_ff.fill;
    assign frame_pixel_counter_out = state_ff.frame_pixel_counter;
    assign frame_line_counter_out = state_ff.frame_line_counter;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_hsync_rise: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        state_ff.run && nxt_state.run
        && state_ff.frame_pixel_counter == state_ff.hsync_assert_pixel |=> hsync_out)
        else $error("hsync not raised at assert pixel");

    chk_hsync_fall: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        state_ff.frame_pixel_counter == state_ff.hsync_release_pixel
        && state_ff.frame_pixel_counter != state_ff.hsync_assert_pixel |=> !hsync_out)
        else $error("hsync not dropped at release pixel");

    chk_vsync_rise: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        state_ff.run && nxt_state.run && !field2_in
        && state_ff.frame_line_counter == state_ff.f1_vsync_assert_line
        && state_ff.frame_pixel_counter == state_ff.f1_vsync_assert_pixel |=> vsync_out)
        else $error("vsync not raised at field 1 assert point");

    chk_vsync_fall: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !field2_in && !vs_set
        && state_ff.frame_line_counter == state_ff.f1_vsync_release_line
        && state_ff.frame_pixel_counter == state_ff.f1_vsync_release_pixel |=> !vsync_out)
        else $error("vsync not dropped at field 1 release point");

    chk_luma_gate: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        fill_req_out.luma && !$past(field2_in) |->
        $past(space_in.luma) >= {1'b0, $past(state_ff.field1_fifo_threshold)})
        else $error("luma request with too little free space");

    chk_chroma_half: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        fill_req_out.cb && !$past(field2_in) |->
        ({$past(space_in.cb), 1'b0} >= {2'b00, $past(state_ff.field1_fifo_threshold)}))
        else $error("cb request below half threshold");

    chk_raw_single: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        state_ff.mode == vdst_pkg::VDST_MODE_RAW ##1
        state_ff.mode == vdst_pkg::VDST_MODE_RAW |-> !fill_req_out.cb && !fill_req_out.cr)
        else $error("chroma request in raw mode");

    chk_reserved_zero: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        bus_in.rd && bus_in.addr <= vdst_pkg::OFF_VSYNC_END |=>
        rdata_out[31:28] == 4'h0 && (($past(bus_in.addr) == vdst_pkg::OFF_THRESHOLD)
        ? (rdata_out[27:26] == 2'h0 && rdata_out[11:10] == 2'h0)
        : (rdata_out[15:12] == 4'h0)))
        else $error("reserved bits read nonzero");

    chk_pixel_step: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        raw_mode && state_ff.run && $changed(state_ff.frame_pixel_counter)
        && state_ff.frame_pixel_counter != 12'h000 |->
        $past(state_ff.step_count) == step_len(state_ff.pixel_step_divider) - 5'h01)
        else $error("raw pixel counter stepped early");

    chk_line_wrap: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        pixel_step && line_end && nxt_state.run && !bus_in.wr |=>
        state_ff.frame_pixel_counter == 12'h000)
        else $error("pixel counter did not restart at line end");

    chk_stopped_quiet: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        !state_ff.run |=> !hsync_out && !vsync_out && state_ff.frame_line_counter == 12'h000)
        else $error("sync active while stopped");

endmodule

/* verification/vdst_display_model.sv */
`timescale 1ns/10ps
// display end: counts the clocks each sync level is seen high
module vdst_display_model (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // count clear, and sync inputs from the port
    input wire logic clr_in,
    input wire logic hsync_in,
    input wire logic vsync_in,
    // measured widths
    output logic [15:0] hs_cnt_out,
    output logic [15:0] vs_cnt_out
);
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            hs_cnt_out <= 16'h0000;
            vs_cnt_out <= 16'h0000;
        end else if (clr_in) begin
            hs_cnt_out <= 16'h0000;
            vs_cnt_out <= 16'h0000;
        end else begin
            hs_cnt_out <= hs_cnt_out + {15'h0, hsync_in};
            vs_cnt_out <= vs_cnt_out + {15'h0, vsync_in};
        end
    end
endmodule

/* verification/vdst_timing_tb_top.sv */
`timescale 1ns/10ps
module vdst_timing_tb_top;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic clr = 1'b0;
    vdst_pkg::vdst_bus_s bus = '0;
    vdst_pkg::vdst_space_s sp = '0;
    logic field2 = 1'b0;
    logic [31:0] rdata;
    vdst_pkg::vdst_fill_s fill;
    logic hs, vs;
    logic [11:0] pc, lc;
    logic [15:0] hn, vn;
    int fails = 0;
    int check_count = 0;
    vdst_timing u_vdst_timing (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus),
        .rdata_out(rdata), .space_in(sp), .field2_in(field2), .fill_req_out(fill),
        .hsync_out(hs), .vsync_out(vs), .frame_pixel_counter_out(pc),
        .frame_line_counter_out(lc));
    vdst_display_model u_vdst_display_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .clr_in(clr), .hsync_in(hs), .vsync_in(vs), .hs_cnt_out(hn), .vs_cnt_out(vn));
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic regs_test();
        rd_chk(8'h00, 32'h00001000);
        rd_chk(8'h04, 32'h00000000);
        wr(8'h00, 32'hffffffff);
        rd_chk(8'h00, 32'h03fff3ff);
        wr(8'h08, 32'hffffffff);
        rd_chk(8'h08, 32'h0fff0fff);
        wr(8'h04, 32'hffffffff);
        rd_chk(8'h04, 32'h0fff0fff);
        wr(8'h0c, 32'hf0f0f0f0);
        rd_chk(8'h0c, 32'h00f000f0);
        rd_chk(8'hfc, 32'h00000000);
        $display("test regs done");
    endtask
    task automatic fill_at(input logic [10:0] y, input logic [10:0] c, input logic f2,
                           input logic [2:0] exp);
        @(posedge clk_sys_in);
        sp <= '{luma: y, cb: c, cr: c};
        field2 <= f2;
        repeat (2) @(posedge clk_sys_in);
        #1 chk({29'h0, fill}, {29'h0, exp});
    endtask
    task automatic fill_test();
        wr(8'h00, 32'h00081005); // thresholds stay above any transfer size
        for (int m = 0; m < 4; m++) begin
            wr(8'h10, 32'(m * 2 + 1));
            fill_at(11'h005, 11'h003, 1'b0, {m < 3, m < 2, m < 2});
        end
        wr(8'h10, 32'h00000001);
        fill_at(11'h004, 11'h002, 1'b0, 3'b000);
        fill_at(11'h007, 11'h004, 1'b1, 3'b011);
        fill_at(11'h008, 11'h003, 1'b1, 3'b100);
        wr(8'h10, 32'h00000000);
        fill_at(11'h3ff, 11'h3ff, 1'b0, 3'b000);
        $display("test fill done");
    endtask
    task automatic sync_test();
        wr(8'h14, 32'h00030009);
        wr(8'h04, 32'h00040002);
        wr(8'h08, 32'h00010003);
        wr(8'h0c, 32'h00020005);
        wr(8'h10, 32'h00000001);
        for (int i = 0; i < 20 && pc !== 12'h002; i++) @(posedge clk_sys_in) #1;
        chk({20'h0, pc}, 32'h2);
        @(posedge clk_sys_in) #1 chk({31'h0, hs}, 32'h1);
        @(posedge clk_sys_in) #1 chk({31'h0, hs}, 32'h1);
        @(posedge clk_sys_in) #1 chk({31'h0, hs}, 32'h0);
        @(posedge clk_sys_in) clr <= 1'b1;
        @(posedge clk_sys_in) clr <= 1'b0;
        repeat (40) @(posedge clk_sys_in);
        #1 chk({16'h0, hn}, 32'h8);
        chk({16'h0, vn}, 32'hc);
        // status is sampled at frame position 20: line 2, pixel 0, vsync high
        repeat (12) @(posedge clk_sys_in);
        rd_chk(8'h18, 32'h20020000);
        chk({20'h0, lc}, 32'h2);
        wr(8'h10, 32'h00000000);
        repeat (2) @(posedge clk_sys_in);
        #1 chk({pc, lc, 6'h0, hs, vs}, 32'h0);
        $display("test sync done");
    endtask
    task automatic step_test(input logic [3:0] n, input int exp);
        int k;
        k = 0;
        wr(8'h00, {16'h0, n, 12'h0});
        wr(8'h10, 32'h00000005);
        for (int i = 0; i < 40 && pc !== 12'h001; i++) @(posedge clk_sys_in) #1;
        while (pc === 12'h001 && k < 40) begin
            @(posedge clk_sys_in) #1;
            k++;
        end
        chk(32'(k), 32'(exp));
        wr(8'h10, 32'h00000000);
        $display("test step done");
    endtask
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        regs_test();
        fill_test();
        sync_test();
        step_test(4'h3, 3);
        step_test(4'h0, 16);
        give_verdict();
    end
endmodule
